/* File: i2c_slave_consts.svh */
`ifndef I2C_SLAVE_CONSTS_SVH
`define I2C_SLAVE_CONSTS_SVH

// Register indexes; byte address is four times the index
`define IDX_SLAVE_CONTROL 8'h09
`define IDX_SLAVE_COMMAND_CONTROL 8'h0A
`define IDX_SLAVE_STATUS 8'h0B
`define IDX_SLAVE_OWN_ADDRESS 8'h0C
`define IDX_SLAVE_SHIFT_DATA 8'h0D

// Slave control fields
`define CTL_ENABLE_BIT 0
`define CTL_AUTO_RESUME_BIT 1
`define CTL_STOP_EVENT_BIT 5
`define CTL_MASK 8'h23

// Command control fields
`define CMD_ACK_SELECT_BIT 2
`define CMD_LSB 0
`define CMD_NONE 2'h0
`define CMD_RESERVED 2'h1
`define CMD_COMPLETE 2'h2
`define CMD_RESPONSE 2'h3

// Status fields
`define ST_BYTE_DONE_BIT 7
`define ST_MATCH_HALT_BIT 6
`define ST_CLASH_BIT 3
`define ST_BUS_ERROR_BIT 2

// Reset values
`define RST_SLAVE_STATUS 8'h00
`define RST_SLAVE_OWN_ADDRESS 8'h00
`define RST_SLAVE_CONTROL 8'h00
`define RST_SHIFT_DATA 8'h00
`endif

/* File: i2c_slave_pkg.sv */
package i2c_slave_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_ADDR = 7'b000_0010,
        ST_HOLD = 7'b000_0100,
        ST_ACK = 7'b000_1000,
        ST_RX = 7'b001_0000,
        ST_TX = 7'b010_0000,
        ST_MACK = 7'b100_0000
    } state_t;

    typedef enum logic [1:0] {
        AFT_IDLE = 2'b00,
        AFT_RX = 2'b01,
        AFT_DATA_HOLD = 2'b10
    } after_t;

    typedef struct packed {
        logic byte_done_flag;
        logic match_or_halt_flag;
        logic scl_stretch_flag;
        logic received_ack_bit;
        logic tx_clash_flag;
        logic bus_error_flag;
        logic dir;
        logic match_or_halt_cause;
    } status_t;

    typedef struct packed {
        logic addr_match;
        logic halt;
        logic byte_done;
        logic clash;
        logic bus_error;
        logic start;
    } events_t;
endpackage : i2c_slave_pkg

/* File: i2c_slave_command_status.sv */
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "i2c_slave_consts.svh"

module i2c_slave_command_status
    import i2c_slave_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk, // System clock
    input wire logic reset_n, // Asynchronous reset
    input wire logic [ADDR_W-1:0] address, // Byte address
    input wire logic read, // Read request
    input wire logic write, // Write request
    input wire logic [31:0] writedata, // Write data
    input wire logic [3:0] byteenable, // Byte lanes
    output logic [31:0] readdata, // Read data
    output logic waitrequest, // Stall
    input wire logic master_enable, // Master side enabled
    input wire logic scl_in, // Bus clock level
    output logic scl_out, // Bus clock drive value
    output logic scl_oe, // Bus clock pulled low
    input wire logic sda_in, // Bus data level
    output logic sda_out, // Bus data drive value
    output logic sda_oe // Bus data pulled low
);

    initial begin
        if (ADDR_W < 6) begin
            $error("ADDR_W too small for the register map");
        end
    end

    // ****************************************
    // Bus pin synchronisers and conditions
    // ****************************************
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
        end
    end

    assign scl_rise = scl_sync[1] && !scl_sync[2];
    assign scl_fall = !scl_sync[1] && scl_sync[2];
    assign start_seen = scl_sync[1] && scl_sync[2] && !sda_sync[1] && sda_sync[2];
    assign stop_seen = scl_sync[1] && scl_sync[2] && sda_sync[1] && !sda_sync[2];

    // ****************************************
    // Register bus slave
    // ****************************************
    logic accept;
    logic wr_lo;
    logic [7:0] index;
    logic mapped;
    logic [7:0] control;
    logic [7:0] own_address;
    logic ack_response_select;
    status_t status;
    logic [7:0] shift;
    logic data_access;
    logic cmd_write;
    logic [1:0] cmd_code;
    logic cmd_exec;
    logic flag_clear;
    logic new_ack;

    assign accept = (read || write) && !waitrequest;
    assign wr_lo = write && !waitrequest && byteenable[0];
    assign index = 8'(address[ADDR_W-1:2]);
    assign mapped = address[1:0] == 2'b00;
    assign data_access = accept && mapped && index == `IDX_SLAVE_SHIFT_DATA && (read || byteenable[0]);
    assign cmd_write = wr_lo && mapped && index == `IDX_SLAVE_COMMAND_CONTROL;
    assign cmd_code = writedata[`CMD_LSB +: 2];
    assign cmd_exec = cmd_write && (cmd_code == `CMD_COMPLETE || cmd_code == `CMD_RESPONSE);
    assign flag_clear = data_access || cmd_exec;
    assign new_ack = cmd_write ? writedata[`CMD_ACK_SELECT_BIT] : ack_response_select;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            waitrequest <= 1'b1;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= 32'h0000_0000;
            if (mapped) begin
                case (index)
                    `IDX_SLAVE_CONTROL: readdata[7:0] <= control;
                    `IDX_SLAVE_COMMAND_CONTROL: readdata[7:0] <= {5'h00, ack_response_select, 2'b00};
                    `IDX_SLAVE_STATUS: readdata[7:0] <= status;
                    `IDX_SLAVE_OWN_ADDRESS: readdata[7:0] <= own_address;
                    `IDX_SLAVE_SHIFT_DATA: readdata[7:0] <= shift;
                    default: readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            control <= `RST_SLAVE_CONTROL;
            own_address <= `RST_SLAVE_OWN_ADDRESS;
            ack_response_select <= 1'b0;
        end else if (wr_lo && mapped) begin
            if (index == `IDX_SLAVE_CONTROL) begin
                control <= writedata[7:0] & `CTL_MASK;
            end
            if (index == `IDX_SLAVE_OWN_ADDRESS) begin
                own_address <= writedata[7:0];
            end
            if (index == `IDX_SLAVE_COMMAND_CONTROL) begin
                ack_response_select <= writedata[`CMD_ACK_SELECT_BIT];
            end
        end
    end

    // ****************************************
    // Slave bus sequencer
    // ****************************************
    state_t state;
    after_t after_ack;
    logic hold_after_data;
    logic [2:0] bit_cnt;
    logic ack_bit;
    logic dir;
    logic rx_ack;
    logic clash_now;
    logic enabled;
    logic resume;
    logic respond;
    logic addr_hit;
    logic mid_byte;
    logic addr_full;
    logic shift_wr;
    events_t ev;

    assign enabled = control[`CTL_ENABLE_BIT];
    assign respond = (cmd_write && cmd_code == `CMD_RESPONSE)
        || (control[`CTL_AUTO_RESUME_BIT] && data_access);
    assign resume = cmd_exec || respond;
    assign shift_wr = wr_lo && mapped && index == `IDX_SLAVE_SHIFT_DATA && state == ST_HOLD;
    assign addr_hit = shift[7:1] == own_address[7:1] || (own_address[0] && shift[7:1] == 7'h00);
    assign mid_byte = state == ST_RX || state == ST_TX || state == ST_MACK || state == ST_ACK
        || (state == ST_ADDR && bit_cnt == 3'h0);
    assign clash_now = scl_rise && sda_oe == 1'b0 && !sda_sync[1]
        && (state == ST_ACK || state == ST_TX);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            after_ack <= AFT_IDLE;
            hold_after_data <= 1'b0;
            bit_cnt <= 3'h0;
            ack_bit <= 1'b0;
            addr_full <= 1'b0;
            dir <= 1'b0;
            rx_ack <= 1'b0;
            shift <= `RST_SHIFT_DATA;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            ev <= '0;
        end else begin
            ev <= '0;
            if (shift_wr) begin
                shift <= writedata[7:0];
            end
            if (!enabled) begin
                state <= ST_IDLE;
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
            end else if (start_seen) begin
                ev.start <= 1'b1;
                addr_full <= 1'b0;
                ev.bus_error <= master_enable && mid_byte && state != ST_ADDR;
                state <= ST_ADDR;
                bit_cnt <= 3'h0;
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_seen) begin
                ev.halt <= control[`CTL_STOP_EVENT_BIT];
                ev.bus_error <= master_enable && mid_byte;
                state <= ST_IDLE;
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
            end else begin
                if (clash_now) begin
                    ev.clash <= 1'b1;
                    sda_oe <= 1'b0;
                end
                case (state)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_sync[1]};
                            bit_cnt <= bit_cnt + 3'h1;
                            addr_full <= bit_cnt == 3'h7;
                        end else if (scl_fall && addr_full) begin
                            // Decide only after all eight address bits, not on the start's own fall
                            addr_full <= 1'b0;
                            if (addr_hit) begin
                                ev.addr_match <= 1'b1;
                                dir <= shift[0];
                                hold_after_data <= 1'b0;
                                scl_oe <= 1'b1;
                                state <= ST_HOLD;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_HOLD: begin
                        if (resume) begin
                            ack_bit <= new_ack;
                            if (cmd_exec && cmd_code == `CMD_COMPLETE) begin
                                after_ack <= AFT_IDLE;
                                if (dir) begin
                                    scl_oe <= 1'b0;
                                    state <= ST_IDLE;
                                end else begin
                                    sda_oe <= !new_ack;
                                    scl_oe <= 1'b0;
                                    state <= ST_ACK;
                                end
                            end else if (dir && hold_after_data) begin
                                // First bit comes from data written in this same cycle when shift_wr, else from shift
                                sda_oe <= !(shift_wr ? writedata[7] : shift[7]);
                                bit_cnt <= 3'h0;
                                scl_oe <= 1'b0;
                                state <= ST_TX;
                            end else begin
                                after_ack <= dir ? AFT_DATA_HOLD : AFT_RX;
                                sda_oe <= !new_ack;
                                scl_oe <= 1'b0;
                                state <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            bit_cnt <= 3'h0;
                            if (ack_bit || after_ack == AFT_IDLE) begin
                                state <= ST_IDLE;
                            end else if (after_ack == AFT_RX) begin
                                state <= ST_RX;
                            end else begin
                                ev.byte_done <= 1'b1;
                                hold_after_data <= 1'b1;
                                scl_oe <= 1'b1;
                                state <= ST_HOLD;
                            end
                        end
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_sync[1]};
                            bit_cnt <= bit_cnt + 3'h1;
                        end else if (scl_fall && bit_cnt == 3'h0) begin
                            ev.byte_done <= 1'b1;
                            hold_after_data <= 1'b1;
                            scl_oe <= 1'b1;
                            state <= ST_HOLD;
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            shift <= {shift[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                sda_oe <= 1'b0;
                                state <= ST_MACK;
                            end else begin
                                sda_oe <= !shift[6] && !status.tx_clash_flag;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            rx_ack <= sda_sync[1];
                        end else if (scl_fall) begin
                            ev.byte_done <= 1'b1;
                            hold_after_data <= 1'b1;
                            scl_oe <= 1'b1;
                            state <= ST_HOLD;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                        scl_oe <= 1'b0;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    // ****************************************
    // Status flags
    // ****************************************
    logic w1c_ok;

    assign w1c_ok = wr_lo && mapped && index == `IDX_SLAVE_STATUS;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status <= `RST_SLAVE_STATUS;
        end else begin
            if (flag_clear || (w1c_ok && writedata[`ST_BYTE_DONE_BIT])) begin
                status.byte_done_flag <= 1'b0;
            end
            if (ev.byte_done) begin
                status.byte_done_flag <= 1'b1;
            end
            if (flag_clear || (w1c_ok && writedata[`ST_MATCH_HALT_BIT])) begin
                status.match_or_halt_flag <= 1'b0;
            end
            if (ev.addr_match || ev.halt) begin
                status.match_or_halt_flag <= 1'b1;
                status.match_or_halt_cause <= ev.addr_match;
            end
            if (ev.start || (w1c_ok && writedata[`ST_CLASH_BIT])) begin
                status.tx_clash_flag <= 1'b0;
            end
            if (ev.clash || clash_now) begin
                status.tx_clash_flag <= 1'b1;
            end
            if (w1c_ok && writedata[`ST_BUS_ERROR_BIT]) begin
                status.bus_error_flag <= 1'b0;
            end
            if (ev.bus_error) begin
                status.bus_error_flag <= 1'b1;
            end
            status.scl_stretch_flag <= scl_oe;
            status.received_ack_bit <= rx_ack;
            status.dir <= dir;
        end
    end

endmodule : i2c_slave_command_status

/* File: i2c_cs_sva.sv */
`timescale 1ns/1ns
module i2c_cs_sva
    import i2c_slave_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic [ADDR_W-1:0] address, // Address
    input wire logic read, // Read
    input wire logic write, // Write
    input wire logic [31:0] writedata, // Data in
    input wire logic [3:0] byteenable, // Lanes
    input wire logic [31:0] readdata, // Data out
    input wire logic waitrequest, // Stall
    input wire logic master_enable, // Master on
    input wire logic scl_in, // Clock line
    input wire logic scl_out, // Clock value
    input wire logic scl_oe, // Clock pull
    input wire logic sda_in, // Data line
    input wire logic sda_out, // Data value
    input wire logic sda_oe // Data pull
);
    localparam logic [ADDR_W-1:0] A_CMD = ADDR_W'(8'h28);
    localparam logic [ADDR_W-1:0] A_ST = ADDR_W'(8'h2C);
    localparam logic [ADDR_W-1:0] A_OWN = ADDR_W'(8'h30);
    logic rd_ok;
    logic wr_ok;
    logic ack_sel;
    logic [7:0] own;
    assign rd_ok = read && !waitrequest;
    assign wr_ok = write && !waitrequest && byteenable[0];
    // ****
    // Shadows of stored bits
    // ****
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_sel <= 1'h0;
        end else if (wr_ok && address == A_CMD) begin
            ack_sel <= writedata[2];
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            own <= 8'h00;
        end else if (wr_ok && address == A_OWN) begin
            own <= writedata[7:0];
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    wait_once_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered in one cycle");
    wait_pulse_a: assert property ($fell(waitrequest) |=> waitrequest)
        else $error("waitrequest low too long");
    cmd_zero_a: assert property (rd_ok && address == A_CMD |-> readdata[1:0] == 2'h0)
        else $error("command field reads nonzero");
    ack_keep_a: assert property (rd_ok && address == A_CMD |-> readdata[2] == ack_sel)
        else $error("ack select lost");
    own_keep_a: assert property (rd_ok && address == A_OWN |-> readdata[7:0] == own)
        else $error("own address lost");
    stretch_bit_a: assert property (rd_ok && address == A_ST && $stable(scl_oe) &&
        $past(scl_oe, 2) == scl_oe && $past(scl_oe, 3) == scl_oe |-> readdata[5] == scl_oe)
        else $error("stretch bit wrong");
    sda_hold_a: assert property ($changed(sda_oe) |-> !$past(scl_in))
        else $error("data changed while clock high");
    open_drain_a: assert property (scl_out == 1'h0 && sda_out == 1'h0)
        else $error("line driven high");
    cover property (rd_ok && address == A_ST && readdata[7]);
    cover property ($rose(scl_oe));
    cover property ($rose(sda_oe));
endmodule : i2c_cs_sva
bind i2c_slave_command_status i2c_cs_sva #(.ADDR_W(ADDR_W)) u_i2c_cs_sva (.sys_clk(sys_clk),
    .reset_n(reset_n), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .master_enable(master_enable), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

/* File: far_master.sv */
`timescale 1ns/1ns
module far_master (
    input wire logic scl_oe, // Slave clock pull
    input wire logic sda_oe, // Slave data pull
    output logic scl_line, // Clock wire
    output logic sda_line // Data wire
);
    logic scl_m = 1'h1;
    logic sda_m = 1'h1;
    // ****
    // Wired AND with pull-ups
    // ****
    assign scl_line = scl_m & ~scl_oe;
    assign sda_line = sda_m & ~sda_oe;
    // One bit: 40 ns low, 24 ns high, stretch honoured
    task automatic bit_cyc(input logic b, output logic s);
        #24 sda_m = b;
        #16 scl_m = 1'h1;
        wait (scl_line);
        #12 s = sda_line;
        #12 scl_m = 1'h0;
    endtask : bit_cyc
    task automatic start;
        #24 sda_m = 1'h1;
        #16 scl_m = 1'h1;
        wait (scl_line);
        #24 sda_m = 1'h0;
        #24 scl_m = 1'h0;
    endtask : start
    task automatic stop;
        #24 sda_m = 1'h0;
        #16 scl_m = 1'h1;
        wait (scl_line);
        #24 sda_m = 1'h1;
        #24;
    endtask : stop
    // Start at once followed by stop, no clock
    task automatic start_stop;
        #24 sda_m = 1'h0;
        #24 sda_m = 1'h1;
        #24;
    endtask : start_stop
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], s);
        end
        bit_cyc(1'h1, ack);
    endtask : send
    task automatic recv(output logic [7:0] d, input logic mack, input logic [7:0] drv);
        logic s;
        for (int i = 0; i < 8; i++) begin
            bit_cyc(drv[7 - i], s);
            d = {d[6:0], s};
        end
        bit_cyc(mack, s);
    endtask : recv
endmodule : far_master

/* File: i2c_slave_command_status_tb.sv */
`timescale 1ns/1ns
module i2c_slave_command_status_tb;
    import i2c_slave_pkg::*;
    logic sys_clk = 1'h0;
    logic reset_n = 1'h0;
    logic [7:0] address = 8'h00;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    logic master_enable = 1'h0;
    logic scl_in;
    logic scl_oe;
    logic sda_in;
    logic sda_oe;
    logic [7:0] q;
    logic [7:0] rx;
    logic a1;
    logic a2;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    always #4 sys_clk = ~sys_clk;
    i2c_slave_command_status u_i2c_slave_command_status (.sys_clk(sys_clk), .reset_n(reset_n),
        .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'h1),
        .readdata(readdata), .waitrequest(waitrequest), .master_enable(master_enable),
        .scl_in(scl_in), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe));
    far_master u_far_master (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_in), .sda_line(sda_in));
    // ****
    // Shared tasks
    // ****
    task automatic end_sim;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        address <= a;
        writedata <= {24'h00_0000, d};
        write <= w;
        read <= !w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (waitrequest !== 1'h0 && n < 50);
        q = readdata[7:0];
        write <= 1'h0;
        read <= 1'h0;
        check({7'h00, n < 50}, 8'h01);
    endtask : bus
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bus(1'h0, a, 8'h00);
        check(q, e);
    endtask : rdc
    task automatic stc(input logic [7:0] m, input logic [7:0] e);
        bus(1'h0, 8'h2C, 8'h00);
        check(q & m, e);
    endtask : stc
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            bus(1'h0, 8'h2C, 8'h00);
            n++;
        end while (q[b] !== 1'h1 && n < 300);
        check(q & (8'h01 << b), 8'h01 << b);
    endtask : poll
    // Stop event, then clear it by writing one
    task automatic halt_clr;
        poll(6);
        stc(8'h41, 8'h40);
        bus(1'h1, 8'h2C, 8'h40);
        stc(8'h40, 8'h00);
    endtask : halt_clr
    // ****
    // Scenarios
    // ****
    task automatic t_regs;
        rdc(8'h2C, 8'h00);
        rdc(8'h30, 8'h00);
        bus(1'h1, 8'h30, 8'hA5);
        rdc(8'h30, 8'hA5);
        bus(1'h1, 8'h28, 8'h07);
        rdc(8'h28, 8'h04);
        bus(1'h1, 8'h28, 8'h00);
        rdc(8'h28, 8'h00);
        bus(1'h1, 8'h2C, 8'hFF);
        rdc(8'h2C, 8'h00);
        bus(1'h1, 8'h3C, 8'h5A);
        rdc(8'h3C, 8'h00);
    endtask : t_regs
    task automatic t_mw;
        bus(1'h1, 8'h24, 8'h21);
        fork
            begin
                u_far_master.start();
                u_far_master.send(8'hA4, a1);
                u_far_master.send(8'h5A, a2);
                u_far_master.stop();
            end
            begin
                poll(6);
                stc(8'hFF, 8'h61);
                bus(1'h1, 8'h28, 8'h01);
                stc(8'hFF, 8'h61);
                bus(1'h1, 8'h28, 8'h00);
                stc(8'hFF, 8'h61);
                bus(1'h1, 8'h28, 8'h03);
                poll(7);
                stc(8'hE2, 8'hA0);
                rdc(8'h34, 8'h5A);
                stc(8'h80, 8'h00);
                bus(1'h1, 8'h28, 8'h06);
            end
        join
        check({7'h00, a1}, 8'h00);
        check({7'h00, a2}, 8'h01);
        halt_clr();
    endtask : t_mw
    task automatic t_mr;
        bus(1'h1, 8'h24, 8'h23);
        fork
            begin
                u_far_master.start();
                u_far_master.send(8'hA5, a1);
                u_far_master.recv(rx, 1'h1, 8'hFE);
                u_far_master.stop();
            end
            begin
                poll(6);
                stc(8'h63, 8'h63);
                bus(1'h1, 8'h28, 8'h03);
                poll(7);
                bus(1'h1, 8'h34, 8'h43);
                poll(7);
                stc(8'h92, 8'h92);
                stc(8'h08, 8'h08);
                bus(1'h1, 8'h28, 8'h02);
            end
        join
        check({7'h00, a1}, 8'h00);
        check(rx, 8'h42);
        halt_clr();
    endtask : t_mr
    task automatic t_gc;
        fork
            begin
                u_far_master.start();
                u_far_master.send(8'h60, a1);
                u_far_master.start();
                u_far_master.send(8'h00, a2);
                u_far_master.stop();
            end
            begin
                poll(6);
                stc(8'h08, 8'h00);
                bus(1'h1, 8'h28, 8'h02);
            end
        join
        check({7'h00, a1}, 8'h01);
        check({7'h00, a2}, 8'h00);
        halt_clr();
    endtask : t_gc
    task automatic t_be;
        @(posedge sys_clk);
        master_enable <= 1'h1;
        u_far_master.start_stop();
        poll(2);
        bus(1'h1, 8'h2C, 8'h04);
        stc(8'h04, 8'h00);
        master_enable <= 1'h0;
        u_far_master.start_stop();
        // Covers the three-flop sync and the flag latency
        repeat (8) @(posedge sys_clk);
        stc(8'h04, 8'h00);
    endtask : t_be
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'h1;
        t_regs();
        t_mw();
        t_mr();
        t_gc();
        t_be();
        end_sim();
    end
endmodule : i2c_slave_command_status_tb
